// >>> design/smt_mode_decode.sv
// Decoder from the five control bits to the state entered on a sleep instruction.
// Assumes purely combinational use by the sequencer; no state of its own.
`timescale 1ns/10ps
module smt_mode_decode
   import smt_pkg::*;
(
   input wire logic [smt_pkg::CTRL_W-1:0] ctrl_i,
   output smt_pkg::smt_state_t target_o,
   output smt_pkg::smt_state_t resume_o,
   output logic defined_o
);
   import smt_pkg::*;

   wire ls = ctrl_i[CTRL_LOW_SPEED_BIT];
   wire ms = ctrl_i[CTRL_MEDIUM_SPEED_BIT];
   wire sb = ctrl_i[CTRL_STANDBY_BIT];
   wire tw = ctrl_i[CTRL_TIMER_WATCH_BIT];
   wire dt = ctrl_i[CTRL_DIRECT_BIT];

   // Active speed named by the medium-speed bit.
   wire smt_state_t act_speed = ms ? SMT_ACTIVE_MED : SMT_ACTIVE_HIGH;

   wire sel_sleep_high = !ls && !ms && !sb && !dt;
   wire sel_sleep_med = !ls && ms && !sb && !dt;
   wire sel_subsleep = ls && !sb && tw && !dt;
   wire sel_standby = !ls && sb && !tw && !dt;
   wire sel_watch = sb && tw && !dt;
   wire sel_direct_act = dt && !ls && !sb;
   wire sel_direct_sb = dt && sb && tw;

   // Only the five bits take part in the choice.
   always_comb begin
      target_o = SMT_ACTIVE_HIGH;
      resume_o = SMT_ACTIVE_HIGH;
      defined_o = 1'b1;
      if (sel_sleep_high) begin
         target_o = SMT_SLEEP_HIGH;
         resume_o = SMT_ACTIVE_HIGH;
      end else if (sel_sleep_med) begin
         target_o = SMT_SLEEP_MED;
         resume_o = SMT_ACTIVE_MED;
      end else if (sel_subsleep) begin
         target_o = SMT_SUBSLEEP;
         resume_o = SMT_SUBACTIVE;
      end else if (sel_standby) begin
         target_o = SMT_STANDBY;
         resume_o = act_speed;
      end else if (sel_watch) begin
         target_o = SMT_WATCH;
         resume_o = ls ? SMT_SUBACTIVE : act_speed;
      end else if (sel_direct_act) begin
         target_o = act_speed;
         resume_o = act_speed;
      end else if (sel_direct_sb) begin
         target_o = ls ? SMT_SUBACTIVE : act_speed;
         resume_o = target_o;
      end else begin
         defined_o = 1'b0;
      end
   end

endmodule : smt_mode_decode

// >>> design/smt_pkg.sv
// Package for the sleep mode transition selector: register map, fields, states.
// Assumes one 8-bit register port and a single clock domain.
package smt_pkg;

   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 8;

   // Register offsets.
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h01;
   localparam logic [7:0] ADDR_COUNT = 8'h02;

   // Control register fields.
   localparam int unsigned CTRL_LOW_SPEED_BIT = 0;
   localparam int unsigned CTRL_MEDIUM_SPEED_BIT = 1;
   localparam int unsigned CTRL_STANDBY_BIT = 2;
   localparam int unsigned CTRL_TIMER_WATCH_BIT = 3;
   localparam int unsigned CTRL_DIRECT_BIT = 4;
   localparam int unsigned CTRL_W = 5;
   localparam logic [4:0] CTRL_RESET = 5'h00;

   // Status register fields.
   localparam int unsigned STAT_STATE_LSB = 0;
   localparam int unsigned STAT_WAKE_LSB = 3;
   localparam int unsigned STAT_UNDEF_BIT = 6;
   localparam int unsigned STAT_SLEEPING_BIT = 7;

   localparam logic [7:0] COUNT_RESET = 8'h00;

   typedef enum logic [2:0] {
      SMT_ACTIVE_HIGH = 3'b000,
      SMT_ACTIVE_MED = 3'b001,
      SMT_SUBACTIVE = 3'b010,
      SMT_SLEEP_HIGH = 3'b011,
      SMT_SLEEP_MED = 3'b100,
      SMT_SUBSLEEP = 3'b101,
      SMT_STANDBY = 3'b110,
      SMT_WATCH = 3'b111
   } smt_state_t;

   localparam smt_state_t STATE_RESET = SMT_ACTIVE_HIGH;

endpackage : smt_pkg

// >>> design/smt_sleep_sequencer.sv
// Top of the sleep mode transition selector with its register port.
// Assumes one clock, synchronous active-high reset, and pulses from the core.
`timescale 1ns/10ps
module smt_sleep_sequencer
   import smt_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic reset_i,
   input wire logic clk_en_i,
   input wire logic [smt_pkg::ADDR_W-1:0] reg_addr_i,
   input wire logic [smt_pkg::DATA_W-1:0] reg_wdata_i,
   input wire logic reg_write_i,
   input wire logic reg_read_i,
   output logic [smt_pkg::DATA_W-1:0] reg_rdata_o,
   input wire logic sleep_instr_i,
   input wire logic wake_irq_i,
   output smt_pkg::smt_state_t power_state_o,
   output logic cpu_run_o,
   output logic sys_osc_en_o,
   output logic medium_speed_o,
   output logic sub_clk_sel_o,
   output logic timers_run_o,
   output logic sleep_done_o
);
   import smt_pkg::*;

   // Register state.
   logic [CTRL_W-1:0] ctrl_q;
   logic [CTRL_W-1:0] ctrl_d;
   logic undef_q;
   logic undef_d;
   logic [DATA_W-1:0] count_q;
   logic [DATA_W-1:0] count_d;
   logic [DATA_W-1:0] rdata_q;
   logic [DATA_W-1:0] rdata_d;

   // Sequencer state.
   smt_state_t state_q;
   smt_state_t state_d;
   smt_state_t resume_q;
   smt_state_t resume_d;
   logic done_q;
   logic done_d;

   // Registered outputs.
   logic cpu_run_q;
   logic osc_en_q;
   logic med_q;
   logic sub_q;
   logic timers_q;

   // Register decode.
   wire hit_ctrl = (reg_addr_i == ADDR_CTRL);
   wire hit_status = (reg_addr_i == ADDR_STATUS);
   wire hit_count = (reg_addr_i == ADDR_COUNT);
   wire wr_ctrl = reg_write_i && hit_ctrl;
   wire wr_status = reg_write_i && hit_status;
   wire wr_count = reg_write_i && hit_count;

   // Mode choice from the control bits.
   smt_state_t sleep_target;
   smt_state_t sleep_resume;
   logic combo_defined;

   smt_mode_decode u_decode (
      .ctrl_i(ctrl_q),
      .target_o(sleep_target),
      .resume_o(sleep_resume),
      .defined_o(combo_defined)
   );

   logic sleeping;
   smt_state_t wake_target;

   smt_wake_select u_wake (
      .state_i(state_q),
      .latched_i(resume_q),
      .ctrl_i(ctrl_q),
      .sleeping_o(sleeping),
      .wake_o(wake_target)
   );

   // A sleep instruction only executes while the core runs.
   wire take_sleep = sleep_instr_i && !sleeping;
   wire take_wake = wake_irq_i && sleeping;
   wire bad_sleep = take_sleep && !combo_defined;
   wire good_sleep = take_sleep && combo_defined;

   // Next state.
   always_comb begin
      state_d = state_q;
      resume_d = resume_q;
      if (good_sleep) begin
         state_d = sleep_target;
         resume_d = sleep_resume;
      end else if (take_wake) begin
         state_d = wake_target;
         resume_d = wake_target;
      end
      // An undefined request falls through and keeps the active state.
   end

   // Sticky undefined flag: a new undefined request wins over a clear.
   assign undef_d = bad_sleep || (undef_q && !(wr_status && reg_wdata_i[STAT_UNDEF_BIT]));

   assign ctrl_d = wr_ctrl ? reg_wdata_i[CTRL_W-1:0] : ctrl_q;

   // Counts accepted sleep instructions; software writes to preset it.
   assign count_d = good_sleep ? count_q + 8'h01 : (wr_count ? reg_wdata_i : count_q);

   assign done_d = good_sleep || take_wake;

   // Read mux, answered one cycle after the strobe.
   wire [DATA_W-1:0] ctrl_word = {{(DATA_W-CTRL_W){1'b0}}, ctrl_q};
   wire [DATA_W-1:0] status_word = {sleeping, undef_q, 3'(resume_q), 3'(state_q)};
   assign rdata_d = !reg_read_i ? 8'h00 :
                    hit_ctrl ? ctrl_word :
                    hit_status ? status_word :
                    hit_count ? count_q : 8'h00;

   // Clock and run controls that follow each state.
   wire run_d = (state_d == SMT_ACTIVE_HIGH) || (state_d == SMT_ACTIVE_MED) ||
                (state_d == SMT_SUBACTIVE);
   wire osc_d = (state_d != SMT_SUBACTIVE) && (state_d != SMT_SUBSLEEP) &&
                (state_d != SMT_STANDBY) && (state_d != SMT_WATCH);
   wire med_d = (state_d == SMT_ACTIVE_MED) || (state_d == SMT_SLEEP_MED);
   wire sub_d = (state_d == SMT_SUBACTIVE) || (state_d == SMT_SUBSLEEP) ||
                (state_d == SMT_WATCH);
   wire timers_d = (state_d != SMT_STANDBY);

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         ctrl_q <= CTRL_RESET;
         undef_q <= 1'b0;
         count_q <= COUNT_RESET;
         rdata_q <= 8'h00;
      end else if (clk_en_i) begin
         ctrl_q <= ctrl_d;
         undef_q <= undef_d;
         count_q <= count_d;
         rdata_q <= rdata_d;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         state_q <= STATE_RESET;
         resume_q <= STATE_RESET;
         done_q <= 1'b0;
      end else if (clk_en_i) begin
         state_q <= state_d;
         resume_q <= resume_d;
         done_q <= done_d;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         cpu_run_q <= 1'b1;
         osc_en_q <= 1'b1;
         med_q <= 1'b0;
         sub_q <= 1'b0;
         timers_q <= 1'b1;
      end else if (clk_en_i) begin
         cpu_run_q <= run_d;
         osc_en_q <= osc_d;
         med_q <= med_d;
         sub_q <= sub_d;
         timers_q <= timers_d;
      end
   end

   assign reg_rdata_o = rdata_q;
   assign power_state_o = state_q;
   assign cpu_run_o = cpu_run_q;
   assign sys_osc_en_o = osc_en_q;
   assign medium_speed_o = med_q;
   assign sub_clk_sel_o = sub_q;
   assign timers_run_o = timers_q;
   assign sleep_done_o = done_q;

endmodule : smt_sleep_sequencer

// >>> design/smt_wake_select.sv
// Picks the active state an interrupt returns to from the current sleep state.
// Assumes the resume target was latched on sleep entry; watch reads live bits.
`timescale 1ns/10ps
module smt_wake_select
   import smt_pkg::*;
(
   input smt_pkg::smt_state_t state_i,
   input smt_pkg::smt_state_t latched_i,
   input wire logic [smt_pkg::CTRL_W-1:0] ctrl_i,
   output logic sleeping_o,
   output smt_pkg::smt_state_t wake_o
);
   import smt_pkg::*;

   wire ls = ctrl_i[CTRL_LOW_SPEED_BIT];
   wire ms = ctrl_i[CTRL_MEDIUM_SPEED_BIT];

   wire smt_state_t watch_exit = ls ? SMT_SUBACTIVE : (ms ? SMT_ACTIVE_MED : SMT_ACTIVE_HIGH);

   assign sleeping_o = (state_i == SMT_SLEEP_HIGH) || (state_i == SMT_SLEEP_MED) ||
                       (state_i == SMT_SUBSLEEP) || (state_i == SMT_STANDBY) ||
                       (state_i == SMT_WATCH);

   // Watch exit follows the low-speed bit at the moment of the interrupt.
   assign wake_o = (state_i == SMT_WATCH) ? watch_exit : latched_i;

endmodule : smt_wake_select

// >>> tb/smt_sleep_chk.sv
// Concurrent checks on the ports of the sleep mode transition selector.
// Assumes one clock and that the control bits change only through register writes.
`timescale 1ns/10ps
module smt_sleep_chk
   import smt_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic reset_i,
   input wire logic clk_en_i,
   input wire logic [smt_pkg::ADDR_W-1:0] reg_addr_i,
   input wire logic [smt_pkg::DATA_W-1:0] reg_wdata_i,
   input wire logic reg_write_i,
   input wire logic sleep_instr_i,
   input wire logic wake_irq_i,
   input smt_pkg::smt_state_t power_state_o,
   input wire logic medium_speed_o,
   input wire logic sub_clk_sel_o,
   input wire logic timers_run_o,
   input wire logic sleep_done_o
);
   // Shadow of the control bits, so that the entry, undefined and watch-wake checks can see what software chose.
   logic [4:0] c_q;
   logic go;
   logic low_wake;
   assign go = clk_en_i && sleep_instr_i && (power_state_o inside {SMT_ACTIVE_HIGH, SMT_ACTIVE_MED, SMT_SUBACTIVE});
   assign low_wake = clk_en_i && wake_irq_i && (power_state_o inside {SMT_SLEEP_HIGH, SMT_SLEEP_MED, SMT_SUBSLEEP});
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         c_q <= 5'h00;
      end else if (clk_en_i && reg_write_i && reg_addr_i == ADDR_CTRL) begin
         c_q <= reg_wdata_i[4:0];
      end
   end
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (reset_i);
   high_sleep_a: assert property (go && !c_q[4] && c_q[2:0] == 3'h0 |=>
      power_state_o == SMT_SLEEP_HIGH && sleep_done_o) else $error("high-speed sleep not entered");
   med_sleep_a: assert property (go && !c_q[4] && c_q[2:0] == 3'h2 |=>
      power_state_o == SMT_SLEEP_MED && medium_speed_o) else $error("medium-speed sleep not entered");
   sub_sleep_a: assert property (go && c_q[4:2] == 3'h2 && c_q[0] |=>
      power_state_o == SMT_SUBSLEEP && sub_clk_sel_o) else $error("subsleep not entered");
   standby_entry_a: assert property (go && c_q[4:2] == 3'h1 && !c_q[0] |=>
      power_state_o == SMT_STANDBY && !timers_run_o) else $error("standby not entered");
   watch_entry_a: assert property (go && c_q[4:2] == 3'h3 |=> power_state_o == SMT_WATCH)
      else $error("watch not entered");
   direct_short_a: assert property (go && c_q[4] && !c_q[2] && !c_q[0] |=>
      power_state_o == ($past(c_q[1]) ? SMT_ACTIVE_MED : SMT_ACTIVE_HIGH)) else $error("direct transfer wrong");
   direct_full_a: assert property (go && c_q[4:2] == 3'h7 |=> power_state_o == ($past(c_q[0]) ?
      SMT_SUBACTIVE : ($past(c_q[1]) ? SMT_ACTIVE_MED : SMT_ACTIVE_HIGH))) else $error("full direct transfer wrong");
   sleep_wake_a: assert property (low_wake |=> power_state_o == ($past(power_state_o) == SMT_SLEEP_HIGH ?
      SMT_ACTIVE_HIGH : ($past(power_state_o) == SMT_SLEEP_MED ? SMT_ACTIVE_MED : SMT_SUBACTIVE)))
      else $error("wrong resume from sleep");
   watch_wake_a: assert property (clk_en_i && wake_irq_i && power_state_o == SMT_WATCH |=>
      power_state_o == ($past(c_q[0]) ? SMT_SUBACTIVE : ($past(c_q[1]) ? SMT_ACTIVE_MED : SMT_ACTIVE_HIGH)))
      else $error("wrong resume from watch");
   undef_hold_a: assert property (go && ((c_q[0] && c_q[4:2] inside {3'h0, 3'h1, 3'h4, 3'h6}) || c_q[4:2] == 3'h5)
      |=> $stable(power_state_o) && !sleep_done_o) else $error("undefined request changed state");
   cover property (go && c_q == 5'h0c);
   cover property (clk_en_i && wake_irq_i && power_state_o == SMT_WATCH);
   cover property (go && c_q[4]);
endmodule : smt_sleep_chk

bind smt_sleep_sequencer smt_sleep_chk chk_u (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .clk_en_i(clk_en_i),
   .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i), .sleep_instr_i(sleep_instr_i),
   .wake_irq_i(wake_irq_i), .power_state_o(power_state_o), .medium_speed_o(medium_speed_o),
   .sub_clk_sel_o(sub_clk_sel_o), .timers_run_o(timers_run_o), .sleep_done_o(sleep_done_o));

// >>> tb/testbench.sv
// Directed bench for the sleep mode transition selector.
// Assumes the checker is bound to the design and the register port answers in one cycle.
`timescale 1ns/10ps
module testbench;
   import smt_pkg::*;
   logic ref_clk_i, reset_i, clk_en_i, reg_write_i, reg_read_i, sleep_instr_i, wake_irq_i;
   logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, rv;
   logic cpu_run_o, sys_osc_en_o, medium_speed_o, sub_clk_sel_o, timers_run_o, sleep_done_o;
   smt_state_t power_state_o;
   int n_mismatch = 0;
   int cmp_count = 0;
   logic [7:0] cnt = 8'h00;
   smt_sleep_sequencer dut_u (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .clk_en_i(clk_en_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
      .reg_rdata_o(reg_rdata_o), .sleep_instr_i(sleep_instr_i), .wake_irq_i(wake_irq_i),
      .power_state_o(power_state_o), .cpu_run_o(cpu_run_o), .sys_osc_en_o(sys_osc_en_o),
      .medium_speed_o(medium_speed_o), .sub_clk_sel_o(sub_clk_sel_o), .timers_run_o(timers_run_o),
      .sleep_done_o(sleep_done_o));
   initial begin
      ref_clk_i = 1'b0;
      forever #25 ref_clk_i = ~ref_clk_i;
   end
   task check(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   // Expected run, oscillator, medium-speed, subclock and timer outputs for a state code.
   function automatic logic [7:0] flags(input logic [2:0] st);
      flags = {3'h0, st <= 3'h2, !(st inside {3'h2, 3'h5, 3'h6, 3'h7}), st inside {3'h1, 3'h4},
               st inside {3'h2, 3'h5, 3'h7}, st != 3'h6};
   endfunction : flags
   task end_sim;
      $display("mismatches=%0d compares=%0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : end_sim
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_write_i <= 1'b1;
      @(posedge ref_clk_i);
      reg_write_i <= 1'b0;
   endtask : wr
   task rd(input logic [7:0] a);
      @(posedge ref_clk_i);
      reg_addr_i <= a;
      reg_read_i <= 1'b1;
      @(posedge ref_clk_i);
      reg_read_i <= 1'b0;
      #1;
      rv = reg_rdata_o;
   endtask : rd
   // One-cycle pulse of the sleep instruction (w low) or of the waking interrupt (w high).
   task pulse(input logic w);
      @(posedge ref_clk_i);
      sleep_instr_i <= !w;
      wake_irq_i <= w;
      @(posedge ref_clk_i);
      sleep_instr_i <= 1'b0;
      wake_irq_i <= 1'b0;
      #1;
   endtask : pulse
   // Sets the control bits, sleeps, and wakes unless r is 7, which marks no sleep state.
   task go(input logic [4:0] c, input logic [2:0] s, input logic [2:0] r, input logic d);
      wr(ADDR_CTRL, {3'h0, c});
      pulse(1'b0);
      check({5'h0, power_state_o}, {5'h0, s});
      check({7'h0, sleep_done_o}, {7'h0, d});
      check({3'h0, cpu_run_o, sys_osc_en_o, medium_speed_o, sub_clk_sel_o, timers_run_o}, flags(s));
      cnt = cnt + {7'h0, d};
      if (r != 3'h7) begin
         pulse(1'b0);
         check({5'h0, power_state_o}, {5'h0, s});
         check({7'h0, sleep_done_o}, 8'h00);
         pulse(1'b1);
         check({5'h0, power_state_o}, {5'h0, r});
         check({7'h0, sleep_done_o}, 8'h01);
         check({3'h0, cpu_run_o, sys_osc_en_o, medium_speed_o, sub_clk_sel_o, timers_run_o}, flags(r));
      end
   endtask : go
   initial begin
      #2000000;
      n_mismatch++;
      end_sim();
   end
   initial begin
      reset_i = 1'b1;
      clk_en_i = 1'b1;
      reg_write_i = 1'b0;
      reg_read_i = 1'b0;
      sleep_instr_i = 1'b0;
      wake_irq_i = 1'b0;
      reg_addr_i = 8'h00;
      reg_wdata_i = 8'h00;
      repeat (8) @(posedge ref_clk_i);
      reset_i <= 1'b0;
      #1;
      check({2'h0, cpu_run_o, sys_osc_en_o, medium_speed_o, sub_clk_sel_o, timers_run_o, sleep_done_o}, 8'h32);
      go(5'h00, 3'h3, 3'h0, 1'b1);
      go(5'h08, 3'h3, 3'h0, 1'b1);
      go(5'h02, 3'h4, 3'h1, 1'b1);
      go(5'h09, 3'h5, 3'h2, 1'b1);
      go(5'h0b, 3'h5, 3'h2, 1'b1);
      go(5'h04, 3'h6, 3'h0, 1'b1);
      go(5'h06, 3'h6, 3'h1, 1'b1);
      go(5'h0c, 3'h7, 3'h0, 1'b1);
      go(5'h0d, 3'h7, 3'h2, 1'b1);
      go(5'h0f, 3'h7, 3'h2, 1'b1);
      go(5'h0e, 3'h7, 3'h1, 1'b1);
      go(5'h10, 3'h0, 3'h7, 1'b1);
      go(5'h12, 3'h1, 3'h7, 1'b1);
      go(5'h1c, 3'h0, 3'h7, 1'b1);
      go(5'h1e, 3'h1, 3'h7, 1'b1);
      go(5'h1d, 3'h2, 3'h7, 1'b1);
      go(5'h1f, 3'h2, 3'h7, 1'b1);
      go(5'h01, 3'h2, 3'h7, 1'b0);
      go(5'h11, 3'h2, 3'h7, 1'b0);
      go(5'h14, 3'h2, 3'h7, 1'b0);
      rd(ADDR_STATUS);
      check(rv & 8'h40, 8'h40);
      wr(ADDR_STATUS, 8'h40);
      rd(ADDR_STATUS);
      check(rv & 8'h40, 8'h00);
      wr(ADDR_CTRL, 8'h00);
      clk_en_i <= 1'b0;
      pulse(1'b0);
      check({5'h0, power_state_o}, 8'h02);
      @(posedge ref_clk_i);
      clk_en_i <= 1'b1;
      pulse(1'b1);
      check({5'h0, power_state_o}, 8'h02);
      rd(ADDR_CTRL);
      check(rv, 8'h00);
      rd(8'h7f);
      check(rv, 8'h00);
      rd(ADDR_COUNT);
      check(rv, cnt);
      end_sim();
   end
endmodule : testbench
